// >>> pkg/scpcr_pkg.sv
package scpcr_pkg;

    // ------------------------------------------------------------------
    // Serial port framing
    // ------------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;

    // ------------------------------------------------------------------
    // Register addresses (word index on the serial port)
    // ------------------------------------------------------------------
    localparam logic [8:0] ADDR_PLL_POWER   = 9'h010;
    localparam logic [8:0] ADDR_PLL_RSV     = 9'h011;
    localparam logic [8:0] ADDR_IO_CLKIN    = 9'h014;
    localparam logic [8:0] ADDR_PLL_LOCK    = 9'h018;
    localparam logic [8:0] ADDR_LOCK_RSV_A  = 9'h01A;
    localparam logic [8:0] ADDR_LOCK_RSV_B  = 9'h01B;
    localparam logic [8:0] ADDR_CLK_GEN     = 9'h020;
    localparam logic [8:0] ADDR_GEN_LOGIC   = 9'h022;
    localparam logic [8:0] ADDR_PIXEL_CORE  = 9'h028;

    // ------------------------------------------------------------------
    // Read/write register table: index, address, reset, writable mask
    // ------------------------------------------------------------------
    localparam int RW_N = 8;
    localparam int IDX_PLL_POWER  = 0;
    localparam int IDX_PLL_RSV    = 1;
    localparam int IDX_IO_CLKIN   = 2;
    localparam int IDX_LOCK_RSV_A = 3;
    localparam int IDX_LOCK_RSV_B = 4;
    localparam int IDX_CLK_GEN    = 5;
    localparam int IDX_GEN_LOGIC  = 6;
    localparam int IDX_PIXEL_CORE = 7;

    localparam logic [8:0] RW_ADDR [RW_N] = '{ADDR_PLL_POWER, ADDR_PLL_RSV, ADDR_IO_CLKIN, ADDR_LOCK_RSV_A,
                                              ADDR_LOCK_RSV_B, ADDR_CLK_GEN, ADDR_GEN_LOGIC, ADDR_PIXEL_CORE};
    localparam logic [15:0] RW_RST [RW_N] = '{16'h0004, 16'h2113, 16'h0000, 16'h2182,
                                              16'h3D2D, 16'h0004, 16'h0000, 16'h0000};
    localparam logic [15:0] RW_MASK [RW_N] = '{16'h0007, 16'hFFFF, 16'h0701, 16'h7FFF,
                                               16'hFFFF, 16'h7F0F, 16'h0001, 16'h0007};

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int BIT_PLL_PWD_N     = 0;
    localparam int BIT_PLL_ENABLE    = 1;
    localparam int BIT_PLL_BYPASS    = 2;
    localparam int BIT_CLKIN_PWD_N   = 0;
    localparam int BIT_PLL_LOCK      = 0;
    localparam int BIT_ANALOG_CLK_EN = 0;
    localparam int BIT_LOGIC_CLK_EN  = 1;
    localparam int BIT_SEL_PLL       = 2;
    localparam int BIT_ADC_8BIT      = 3;
    localparam int BIT_LOGIC_ENABLE  = 0;
    localparam int BIT_IMC_PWD_N     = 0;
    localparam int BIT_MUX_PWD_N     = 1;
    localparam int BIT_COLBIAS_EN    = 2;

endpackage

// >>> hw/scpcr_spi_slave.sv
`timescale 1ns/1ps

module scpcr_spi_slave #(
    parameter int ADDR_W = 9,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Serial configuration pins
    input  wire logic              spi_sclk,
    input  wire logic              spi_cs_b,
    input  wire logic              spi_mosi,
    output logic                   spi_miso,
    output logic                   spi_miso_oe,
    // Register side
    output logic [ADDR_W-1:0]      reg_addr,
    output logic                   reg_wr_stb,
    output logic [DATA_W-1:0]      reg_wdata,
    input  wire logic [DATA_W-1:0] reg_rdata
);

    localparam int CMD_BITS = ADDR_W + 1;
    localparam int CNT_W    = $clog2((CMD_BITS > DATA_W) ? CMD_BITS : DATA_W);

    typedef enum logic [1:0] {ST_CMD, ST_LOAD, ST_DATA, ST_DONE} scpcr_spi_st_t;

    scpcr_spi_st_t       st_r;
    logic                sclk_q_r;
    logic [CNT_W-1:0]    cnt_r;
    logic [CMD_BITS-1:0] cmd_r;
    logic [DATA_W-1:0]   data_r;
    logic [DATA_W-1:0]   tx_r;
    logic                wr_stb_r;

    // Pins are synchronous to ref_clk, so edges come from one delayed copy
    wire sclk_rise = spi_sclk & ~sclk_q_r;
    wire sclk_fall = ~spi_sclk & sclk_q_r;
    wire is_write  = cmd_r[0];

    assign reg_addr    = cmd_r[CMD_BITS-1:1];
    assign reg_wdata   = data_r;
    assign reg_wr_stb  = wr_stb_r;
    assign spi_miso    = tx_r[DATA_W-1];
    assign spi_miso_oe = ~spi_cs_b & ~is_write & ((st_r == ST_DATA) | (st_r == ST_LOAD));

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r     <= ST_CMD;
            sclk_q_r <= 1'b0;
            cnt_r    <= '0;
            cmd_r    <= '0;
            data_r   <= '0;
            tx_r     <= '0;
            wr_stb_r <= 1'b0;
        end
        else
        begin
            sclk_q_r <= spi_sclk;
            wr_stb_r <= 1'b0;
            if (spi_cs_b)
            begin
                st_r  <= ST_CMD;
                cnt_r <= '0;
            end
            else
            begin
                case (st_r)
                    ST_CMD:
                    begin
                        if (sclk_rise)
                        begin
                            cmd_r <= {cmd_r[CMD_BITS-2:0], spi_mosi};
                            cnt_r <= (cnt_r == CNT_W'(CMD_BITS - 1)) ? '0 : cnt_r + 1'b1;
                            if (cnt_r == CNT_W'(CMD_BITS - 1))
                                st_r <= ST_LOAD;
                        end
                    end
                    ST_LOAD:
                    begin
                        tx_r <= reg_rdata;
                        st_r <= ST_DATA;
                    end
                    ST_DATA:
                    begin
                        if (sclk_rise)
                        begin
                            data_r <= {data_r[DATA_W-2:0], spi_mosi};
                            cnt_r  <= cnt_r + 1'b1;
                            if (cnt_r == CNT_W'(DATA_W - 1))
                            begin
                                st_r     <= ST_DONE;
                                wr_stb_r <= is_write;
                            end
                        end
                        else if (sclk_fall && cnt_r != '0)
                            tx_r <= {tx_r[DATA_W-2:0], 1'b0};
                    end
                    ST_DONE:
                        st_r <= ST_DONE;
                    default:
                        st_r <= ST_CMD;
                endcase
            end
        end
    end

endmodule

// >>> hw/scpcr_regs.sv
`timescale 1ns/1ps

// Overview of operation
// [R01] I/O register bit 0 powers down the clock input receiver; resets to 0.
// [R02] Clock generator bit 0 enables the analog clocks; reset disabled.
// [R03] Clock generator bit 1 enables the logic clock; reset disabled.
// [R04] Clock generator bit 2 picks PLL (1) or LVDS clock (0); resets to PLL.
// [R05] Clock generator bit 3 picks 8-bit (1) or 10-bit (0) conversion; reset 10-bit.
// [R06] General logic bit 0 is the master logic enable; reset disabled.
// [R07] Image core bit 0, active low, powers the pixel core; resets down.
// [R08] Image core bit 1, active low, powers the column multiplexer; resets down.
// [R09] PLL power bit 0, active low, powers the PLL; resets down.
// [R10] Software keeps reserved registers and fields at their default values.

module scpcr_regs #(
    parameter int ADDR_W = scpcr_pkg::ADDR_W,
    parameter int DATA_W = scpcr_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Serial configuration port
    input  wire logic spi_sclk,
    input  wire logic spi_cs_b,
    input  wire logic spi_mosi,
    output logic      spi_miso,
    output logic      spi_miso_oe,
    // Status from the analog side
    input  wire logic pll_lock_in,
    // PLL controls
    output logic      pll_pwd_n,
    output logic      pll_enable,
    output logic      pll_bypass,
    // Clock input and clock generator controls
    output logic      clock_in_pwd_n,
    output logic      analog_clk_en,
    output logic      logic_clk_en,
    output logic      clk_sel_pll,
    output logic      adc_8bit_mode,
    // Logic and image core controls
    output logic      logic_enable,
    output logic      pixel_core_pwd_n,
    output logic      col_mux_pwd_n,
    output logic      col_bias_en
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (DATA_W != 16)
        $error("scpcr_regs: DATA_W must be 16");
    if (ADDR_W < 6 || ADDR_W > 9)
        $error("scpcr_regs: ADDR_W must lie in 6..9");

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [8:0] target);
        addr_is = ({{(9 - ADDR_W + 1){1'b0}}, a} == {1'b0, target});
    endfunction

    logic [ADDR_W-1:0] reg_addr;
    logic              reg_wr_stb;
    logic [DATA_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] rw_r [scpcr_pkg::RW_N];
    logic              lock_r;
    logic [scpcr_pkg::RW_N-1:0] rd_hit;
    logic [scpcr_pkg::RW_N-1:0] wr_hit;

    wire lock_hit = addr_is(reg_addr, scpcr_pkg::ADDR_PLL_LOCK);

    // ------------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------------
    scpcr_spi_slave #(
        .ADDR_W (ADDR_W),
        .DATA_W (DATA_W)
    ) u_spi (
        .ref_clk     (ref_clk),
        .rst_b       (rst_b),
        .spi_sclk    (spi_sclk),
        .spi_cs_b    (spi_cs_b),
        .spi_mosi    (spi_mosi),
        .spi_miso    (spi_miso),
        .spi_miso_oe (spi_miso_oe),
        .reg_addr    (reg_addr),
        .reg_wr_stb  (reg_wr_stb),
        .reg_wdata   (reg_wdata),
        .reg_rdata   (reg_rdata)
    );

    // ------------------------------------------------------------------
    // Read/write registers
    // ------------------------------------------------------------------
    // Undefined bits are not stored, so they read zero whatever is written
    for (genvar i = 0; i < scpcr_pkg::RW_N; i++)
    begin : g_rw
        assign rd_hit[i] = addr_is(reg_addr, scpcr_pkg::RW_ADDR[i]);
        assign wr_hit[i] = reg_wr_stb & rd_hit[i];

        always_ff @(posedge ref_clk or negedge rst_b)
        begin
            if (!rst_b)
                rw_r[i] <= scpcr_pkg::RW_RST[i];
            else if (wr_hit[i])
                rw_r[i] <= reg_wdata & scpcr_pkg::RW_MASK[i];
        end
    end

    // Lock status is read only; writes to its address are dropped
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            lock_r <= 1'b0;
        else
            lock_r <= pll_lock_in;
    end

    // ------------------------------------------------------------------
    // Read selection
    // ------------------------------------------------------------------
    always_comb
    begin
        reg_rdata = '0;
        for (int i = 0; i < scpcr_pkg::RW_N; i++)
        begin
            if (rd_hit[i])
                reg_rdata = rw_r[i];
        end
        if (lock_hit)
            reg_rdata = DATA_W'({lock_r} << scpcr_pkg::BIT_PLL_LOCK);
    end

    // ------------------------------------------------------------------
    // Control outputs
    // ------------------------------------------------------------------
    assign pll_pwd_n        = rw_r[scpcr_pkg::IDX_PLL_POWER][scpcr_pkg::BIT_PLL_PWD_N];      // R09
    assign pll_enable       = rw_r[scpcr_pkg::IDX_PLL_POWER][scpcr_pkg::BIT_PLL_ENABLE];
    assign pll_bypass       = rw_r[scpcr_pkg::IDX_PLL_POWER][scpcr_pkg::BIT_PLL_BYPASS];
    assign clock_in_pwd_n   = rw_r[scpcr_pkg::IDX_IO_CLKIN][scpcr_pkg::BIT_CLKIN_PWD_N];     // R01
    assign analog_clk_en    = rw_r[scpcr_pkg::IDX_CLK_GEN][scpcr_pkg::BIT_ANALOG_CLK_EN];    // R02
    assign logic_clk_en     = rw_r[scpcr_pkg::IDX_CLK_GEN][scpcr_pkg::BIT_LOGIC_CLK_EN];     // R03
    assign clk_sel_pll      = rw_r[scpcr_pkg::IDX_CLK_GEN][scpcr_pkg::BIT_SEL_PLL];          // R04
    assign adc_8bit_mode    = rw_r[scpcr_pkg::IDX_CLK_GEN][scpcr_pkg::BIT_ADC_8BIT];         // R05
    assign logic_enable     = rw_r[scpcr_pkg::IDX_GEN_LOGIC][scpcr_pkg::BIT_LOGIC_ENABLE];   // R06
    assign pixel_core_pwd_n = rw_r[scpcr_pkg::IDX_PIXEL_CORE][scpcr_pkg::BIT_IMC_PWD_N];     // R07
    assign col_mux_pwd_n    = rw_r[scpcr_pkg::IDX_PIXEL_CORE][scpcr_pkg::BIT_MUX_PWD_N];     // R08
    assign col_bias_en      = rw_r[scpcr_pkg::IDX_PIXEL_CORE][scpcr_pkg::BIT_COLBIAS_EN];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    wire wr_io   = wr_hit[scpcr_pkg::IDX_IO_CLKIN];
    wire wr_cgen = wr_hit[scpcr_pkg::IDX_CLK_GEN];
    wire wr_gen  = wr_hit[scpcr_pkg::IDX_GEN_LOGIC];
    wire wr_imc  = wr_hit[scpcr_pkg::IDX_PIXEL_CORE];
    wire wr_pll  = wr_hit[scpcr_pkg::IDX_PLL_POWER];

    AST_CLKIN_WRITE: assert property ( // R01
        @(posedge ref_clk) disable iff (!rst_b)
        wr_io |=> (clock_in_pwd_n == $past(reg_wdata[scpcr_pkg::BIT_CLKIN_PWD_N])))
        else $error("clock input power-down does not follow write");

    AST_ANALOG_CLK: assert property ( // R02
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_cgen && !reg_wdata[scpcr_pkg::BIT_ANALOG_CLK_EN]) |=> !analog_clk_en ##1 (!analog_clk_en || $past(wr_cgen)))
        else $error("analog clock enable wrong after write");

    AST_LOGIC_CLK: assert property ( // R03
        @(posedge ref_clk) disable iff (!rst_b)
        (wr_cgen && reg_wdata[scpcr_pkg::BIT_LOGIC_CLK_EN]) |=> logic_clk_en)
        else $error("logic clock not enabled after write");

    AST_SEL_STABLE: assert property ( // R04
        @(posedge ref_clk) disable iff (!rst_b)
        !wr_cgen |=> $stable(clk_sel_pll))
        else $error("clock source changed without a write");

    AST_ADC_MODE_READ: assert property ( // R05
        @(posedge ref_clk) disable iff (!rst_b)
        addr_is(reg_addr, scpcr_pkg::ADDR_CLK_GEN) |-> (reg_rdata[scpcr_pkg::BIT_ADC_8BIT] == adc_8bit_mode))
        else $error("conversion mode readback mismatch");

    AST_LOGIC_ENABLE: assert property ( // R06
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(logic_enable) |-> $past(wr_gen))
        else $error("logic enable rose without a write");

    AST_PIXEL_CORE_READ: assert property ( // R07
        @(posedge ref_clk) disable iff (!rst_b)
        addr_is(reg_addr, scpcr_pkg::ADDR_PIXEL_CORE) |-> (reg_rdata[scpcr_pkg::BIT_IMC_PWD_N] == pixel_core_pwd_n))
        else $error("pixel core power readback mismatch");

    AST_COL_MUX_WRITE: assert property ( // R08
        @(posedge ref_clk) disable iff (!rst_b)
        wr_imc |=> (col_mux_pwd_n == $past(reg_wdata[scpcr_pkg::BIT_MUX_PWD_N])))
        else $error("column mux power does not follow write");

    AST_PLL_PWD: assert property ( // R09
        @(posedge ref_clk) disable iff (!rst_b)
        $changed(pll_pwd_n) |-> ($past(wr_pll) && (pll_pwd_n == $past(reg_wdata[scpcr_pkg::BIT_PLL_PWD_N]))))
        else $error("PLL power changed without a matching write");

endmodule

// >>> verification/tb_scpcr_regs.sv
`timescale 1ns/1ps

module tb_scpcr_regs;

    // ------------------------------------------------------------------
    // Pins and bench state
    // ------------------------------------------------------------------
    logic        ref_clk     = 1'b0;
    logic        rst_b       = 1'b0;
    logic        spi_sclk    = 1'b0;
    logic        spi_cs_b    = 1'b1;
    logic        spi_mosi    = 1'b0;
    logic        pll_lock_in = 1'b0;
    logic        spi_miso, spi_miso_oe, pll_pwd_n, pll_enable, pll_bypass, clock_in_pwd_n;
    logic        analog_clk_en, logic_clk_en, clk_sel_pll, adc_8bit_mode;
    logic        logic_enable, pixel_core_pwd_n, col_mux_pwd_n, col_bias_en;
    logic [15:0] mdl [scpcr_pkg::RW_N];
    logic [15:0] rd;
    logic [8:0]  addr;
    integer      seed = 32'h0963;
    int          n_errors;
    int          checks_done;
    int          k;

    always #50 ref_clk = ~ref_clk;

    scpcr_regs i_dut (
        .ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
        .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .pll_lock_in(pll_lock_in), .pll_pwd_n(pll_pwd_n),
        .pll_enable(pll_enable), .pll_bypass(pll_bypass), .clock_in_pwd_n(clock_in_pwd_n),
        .analog_clk_en(analog_clk_en), .logic_clk_en(logic_clk_en), .clk_sel_pll(clk_sel_pll),
        .adc_8bit_mode(adc_8bit_mode), .logic_enable(logic_enable), .pixel_core_pwd_n(pixel_core_pwd_n),
        .col_mux_pwd_n(col_mux_pwd_n), .col_bias_en(col_bias_en)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Every drive lands 10 ns after a rising edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask

    // Three-cycle sclk phases keep the two-cycle minimum with margin
    task automatic frame(input logic [8:0] a, input logic wr, input logic [15:0] d, input int nbits);
        logic [25:0] sh;
        sh = {a, wr, d};
        rd = 16'h0000;
        spi_cs_b = 1'b0;
        step(1);
        for (int i = 0; i < nbits; i++)
        begin
            spi_mosi = sh[25-i];
            spi_sclk = 1'b0;
            step(3);
            if (i >= 10)
            begin
                rd = {rd[14:0], spi_miso};
                chk(16'(spi_miso_oe), {15'h0000, ~wr}, "miso_oe in frame");
            end
            spi_sclk = 1'b1;
            step(3);
        end
        spi_sclk = 1'b0;
        step(3);
        spi_cs_b = 1'b1;
        spi_mosi = 1'($random(seed));
        step(2);
        chk(16'(spi_miso_oe), 16'h0000, "miso_oe idle");
    endtask

    function automatic logic [15:0] exp_rd(input logic [8:0] a);
        exp_rd = 16'h0000;
        for (int j = 0; j < scpcr_pkg::RW_N; j++)
            if (scpcr_pkg::RW_ADDR[j] == a)
                exp_rd = mdl[j];
        if (a == scpcr_pkg::ADDR_PLL_LOCK)
            exp_rd = {15'h0000, pll_lock_in};
    endfunction

    // Reserved fields go out at their defaults, as software is expected to do
    function automatic logic [15:0] keep_rsv(input logic [8:0] a, input logic [15:0] d);
        logic [15:0] m;
        case (a)
            scpcr_pkg::ADDR_PLL_RSV:    m = 16'hFFFF;
            scpcr_pkg::ADDR_IO_CLKIN:   m = 16'h0700;
            scpcr_pkg::ADDR_LOCK_RSV_A: m = 16'h7FFF;
            scpcr_pkg::ADDR_LOCK_RSV_B: m = 16'hFFFF;
            scpcr_pkg::ADDR_CLK_GEN:    m = 16'h7F00;
            default:                    m = 16'h0000;
        endcase
        keep_rsv = d;
        for (int j = 0; j < scpcr_pkg::RW_N; j++)
            if (scpcr_pkg::RW_ADDR[j] == a)
                keep_rsv = (d & ~m) | (scpcr_pkg::RW_RST[j] & m);
    endfunction

    task automatic wr_reg(input logic [8:0] a, input logic [15:0] d);
        logic [15:0] dk;
        dk = keep_rsv(a, d);
        frame(a, 1'b1, dk, 26);
        for (int j = 0; j < scpcr_pkg::RW_N; j++)
            if (scpcr_pkg::RW_ADDR[j] == a)
                mdl[j] = dk & scpcr_pkg::RW_MASK[j];
    endtask

    task automatic rd_reg(input logic [8:0] a);
        frame(a, 1'b0, 16'h0000, 26);
        chk(rd, exp_rd(a), $sformatf("readback %h", a));
    endtask

    task automatic chk_outs();
        chk(16'(pll_pwd_n), 16'(mdl[scpcr_pkg::IDX_PLL_POWER][0]), "pll_pwd_n");
        chk(16'(pll_enable), 16'(mdl[scpcr_pkg::IDX_PLL_POWER][1]), "pll_enable");
        chk(16'(pll_bypass), 16'(mdl[scpcr_pkg::IDX_PLL_POWER][2]), "pll_bypass");
        chk(16'(clock_in_pwd_n), 16'(mdl[scpcr_pkg::IDX_IO_CLKIN][0]), "clock_in_pwd_n");
        chk(16'(analog_clk_en), 16'(mdl[scpcr_pkg::IDX_CLK_GEN][0]), "analog_clk_en");
        chk(16'(logic_clk_en), 16'(mdl[scpcr_pkg::IDX_CLK_GEN][1]), "logic_clk_en");
        chk(16'(clk_sel_pll), 16'(mdl[scpcr_pkg::IDX_CLK_GEN][2]), "clk_sel_pll");
        chk(16'(adc_8bit_mode), 16'(mdl[scpcr_pkg::IDX_CLK_GEN][3]), "adc_8bit_mode");
        chk(16'(logic_enable), 16'(mdl[scpcr_pkg::IDX_GEN_LOGIC][0]), "logic_enable");
        chk(16'(pixel_core_pwd_n), 16'(mdl[scpcr_pkg::IDX_PIXEL_CORE][0]), "pixel_core_pwd_n");
        chk(16'(col_mux_pwd_n), 16'(mdl[scpcr_pkg::IDX_PIXEL_CORE][1]), "col_mux_pwd_n");
        chk(16'(col_bias_en), 16'(mdl[scpcr_pkg::IDX_PIXEL_CORE][2]), "col_bias_en");
    endtask

    // Defaults reloaded into the model, then every register read back
    task automatic reset_and_check();
        rst_b = 1'b0;
        step(3);
        rst_b = 1'b1;
        step(2);
        for (int j = 0; j < scpcr_pkg::RW_N; j++)
            mdl[j] = scpcr_pkg::RW_RST[j];
        chk({12'h000, adc_8bit_mode, clk_sel_pll, logic_clk_en, analog_clk_en}, 16'h0004, "clock generator default");
        chk_outs();
        for (int j = 0; j < scpcr_pkg::RW_N; j++)
            rd_reg(scpcr_pkg::RW_ADDR[j]);
        rd_reg(scpcr_pkg::ADDR_PLL_LOCK);
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        step(1);
        reset_and_check();
        $display("test reset defaults done");
        for (k = 0; k < scpcr_pkg::RW_N; k++)
        begin
            wr_reg(scpcr_pkg::RW_ADDR[k], 16'hFFFF);
            chk_outs();
            rd_reg(scpcr_pkg::RW_ADDR[k]);
            wr_reg(scpcr_pkg::RW_ADDR[k], 16'h0000);
            chk_outs();
        end
        $display("test all ones and zeros done");
        repeat (40)
        begin
            k = $unsigned($random(seed)) % scpcr_pkg::RW_N;
            addr = (($random(seed) & 3) == 0) ? 9'($random(seed)) : scpcr_pkg::RW_ADDR[k];
            wr_reg(addr, 16'($random(seed)));
            chk_outs();
            rd_reg(addr);
        end
        $display("test random writes done");
        pll_lock_in = 1'b1;
        step(2);
        wr_reg(scpcr_pkg::ADDR_PLL_LOCK, 16'h0000);
        rd_reg(scpcr_pkg::ADDR_PLL_LOCK);
        wr_reg(9'h1FF, 16'hFFFF);
        rd_reg(9'h1FF);
        rd_reg(9'h015);
        chk_outs();
        $display("test read-only and unmapped done");
        frame(scpcr_pkg::ADDR_CLK_GEN, 1'b1, keep_rsv(scpcr_pkg::ADDR_CLK_GEN, ~mdl[scpcr_pkg::IDX_CLK_GEN]), 15);
        frame(scpcr_pkg::ADDR_PIXEL_CORE, 1'b1, ~mdl[scpcr_pkg::IDX_PIXEL_CORE], 25);
        chk_outs();
        rd_reg(scpcr_pkg::ADDR_CLK_GEN);
        $display("test aborted frames done");
        for (k = 0; k < scpcr_pkg::RW_N; k++)
            wr_reg(scpcr_pkg::RW_ADDR[k], 16'hFFFF);
        pll_lock_in = 1'b0;
        reset_and_check();
        $display("test second reset done");
        give_verdict();
    end

    // Roughly 140 frames of about 165 cycles each are expected
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        give_verdict();
    end

endmodule
